/* File: common/fspc_link_if.sv */
// Pin-level link between the host and the scan generator device
`timescale 1ns/100ps
`default_nettype none
interface fspc_link_if;
	logic sclk;
	logic frame_sync_n;
	logic serial_data_in;
	logic scan_trigger_in;
	logic scan_abort_in;
	logic sleep_in;
	logic scan_status_out;
	logic sign_bit_out;
	// Device end
	modport dev (
		input sclk,
		input frame_sync_n,
		input serial_data_in,
		input scan_trigger_in,
		input scan_abort_in,
		input sleep_in,
		output scan_status_out,
		output sign_bit_out
	);
	// Host end
	modport host (
		output sclk,
		output frame_sync_n,
		output serial_data_in,
		output scan_trigger_in,
		output scan_abort_in,
		output sleep_in,
		input scan_status_out,
		input sign_bit_out
	);
endinterface
`default_nettype wire

/* File: common/fspc_pkg.sv */
// Shared constants and types of the frequency scan pin control block
`default_nettype none
package fspc_pkg;
	// Serial word layout: address nibble first, then data MSB to LSB
	localparam int WORD_BITS = 16;
	localparam int ADDR_BITS = 4;
	localparam int DATA_BITS = 12;
	// Device register addresses carried in the word's address nibble
	localparam logic [3:0] ADDR_CTRL = 4'h0;
	localparam logic [3:0] ADDR_START_LO = 4'h1;
	localparam logic [3:0] ADDR_START_HI = 4'h2;
	localparam logic [3:0] ADDR_DELTA_LO = 4'h3;
	localparam logic [3:0] ADDR_DELTA_HI = 4'h4;
	localparam logic [3:0] ADDR_NINCR = 4'h5;
	localparam logic [3:0] ADDR_TINT = 4'h6;
	// Control register bit positions
	localparam int CTRL_AUTO = 0;
	localparam int CTRL_SRC_SEL = 1;
	localparam int CTRL_STAT_EN = 2;
	localparam int CTRL_SIGN_EN = 3;
	localparam logic [11:0] CTRL_RST = 12'h000;
	// Synthesis widths and DAC code at rest
	localparam int FREQ_BITS = 24;
	localparam int DAC_BITS = 10;
	localparam logic [9:0] DAC_MIDSCALE = 10'h200;
	// Status pin stretch so a 3-flop sampler on the far side sees it
	localparam logic [2:0] STATUS_HOLD = 3'h4;
	// Serial clock made by the host: period from system period
	localparam int SYS_PERIOD_NS = 10;
	localparam int SCLK_PERIOD_NS = 160;
	localparam int SCLK_HALF = SCLK_PERIOD_NS / SYS_PERIOD_NS / 2;
	// Host Wishbone register offsets and bit positions
	localparam logic [7:0] HOST_CMD = 8'h00;
	localparam logic [7:0] HOST_STATUS = 8'h04;
	localparam logic [7:0] HOST_PINS = 8'h08;
	localparam logic [7:0] HOST_IRQ_STAT = 8'h0c;
	localparam logic [7:0] HOST_IRQ_MASK = 8'h10;
	localparam int CMD_KEEP = 16;
	localparam int PIN_TRIG = 0;
	localparam int PIN_ABORT = 1;
	localparam int PIN_SLEEP = 2;
	localparam int IRQ_WORD = 0;
	localparam int IRQ_SCAN = 1;
	// Device scan sequencer states
	typedef enum logic [2:0] {
		FSPC_IDLE = 3'b001,
		FSPC_RUN = 3'b010,
		FSPC_DONE = 3'b100
	} fspc_scan_state_type;
	// Host transmitter states
	typedef enum logic [2:0] {
		FSPC_TX_IDLE = 3'b001,
		FSPC_TX_HIGH = 3'b010,
		FSPC_TX_LOW = 3'b100
	} fspc_tx_state_type;
endpackage
`default_nettype wire

/* File: dv/frequency_scan_pin_control_tb.sv */
// Self-checking bench: host end and device end joined over the link
`timescale 1ns/100ps
`default_nettype none
module frequency_scan_pin_control_tb;
	logic clk_sys = 1'h0;
	logic rst = 1'h1;
	logic cyc = 1'h0;
	logic stb = 1'h0;
	logic we = 1'h0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic ack;
	logic irq;
	logic [9:0] dac_code;
	logic [9:0] d0;
	logic scan_running;
	logic [31:0] rs = 32'h57;
	logic [31:0] q;
	logic [31:0] r;
	logic sclk_q = 1'h1;
	logic stat_q = 1'h0;
	logic exp_bits[$];
	int mismatches = 0;
	int n_tests = 0;
	int stat_cnt = 0;
	int sign_cnt = 0;
	int k;
	fspc_link_if link();
	fspc_host i_fspc_host (.LINK(link), .CLK_SYS(clk_sys), .RST(rst),
		.WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr),
		.WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
		.IRQ(irq));
	fspc_device i_fspc_device (.LINK(link), .CLK_SYS(clk_sys), .RST(rst),
		.DAC_CODE(dac_code), .SCAN_RUNNING(scan_running));
	fspc_link_props i_fspc_link_props (.CLK_SYS(clk_sys), .RST(rst),
		.sclk(link.sclk), .frame_sync_n(link.frame_sync_n),
		.serial_data_in(link.serial_data_in),
		.scan_trigger_in(link.scan_trigger_in),
		.scan_abort_in(link.scan_abort_in), .sleep_in(link.sleep_in),
		.scan_status_out(link.scan_status_out),
		.sign_bit_out(link.sign_bit_out), .DAC_CODE(dac_code),
		.SCAN_RUNNING(scan_running));
	// Clock of 10 ns
	initial forever #5 clk_sys = ~clk_sys;
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			mismatches++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task end_sim;
		if (mismatches == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	function logic [31:0] xs();
		rs = rs ^ (rs << 13);
		rs = rs ^ (rs >> 17);
		rs = rs ^ (rs << 5);
		return rs;
	endfunction
	// One classic cycle; waits on ack, bounded so a dead slave ends
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		wdat <= d;
		n = 0;
		do
		begin
			@(posedge clk_sys);
			n++;
		end
		while (ack !== 1'h1 && n < 50);
		q = rdat;
		cyc <= 1'h0;
		stb <= 1'h0;
		if (n >= 50)
			chk(32'h0, 32'h1);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] exp);
		wb(1'h0, a, 32'h0);
		chk(q, exp);
	endtask
	// Queue the expected wire bits, start the word, poll busy away
	task send(input logic [15:0] w, input logic keep);
		int n;
		for (int i = 15; i >= 0; i--)
			exp_bits.push_back(w[i]);
		wb(1'h1, fspc_pkg::HOST_CMD, {15'h0, keep, w});
		n = 0;
		do
		begin
			wb(1'h0, fspc_pkg::HOST_STATUS, 32'h0);
			n++;
		end
		while (q[0] !== 1'h0 && n < 200);
		if (n >= 200)
			chk(32'h0, 32'h1);
	endtask
	task word(input logic [3:0] a, input logic [11:0] d);
		send({a, d}, 1'h0);
	endtask
	// Control first, since writing it resets the sequencer
	task prog(input logic [11:0] c, input logic [11:0] ni,
		input logic [11:0] ti);
		word(fspc_pkg::ADDR_CTRL, c);
		word(fspc_pkg::ADDR_START_LO, 12'h000);
		word(fspc_pkg::ADDR_START_HI, 12'h010);
		word(fspc_pkg::ADDR_DELTA_LO, 12'h000);
		word(fspc_pkg::ADDR_DELTA_HI, 12'h004);
		word(fspc_pkg::ADDR_NINCR, ni);
		word(fspc_pkg::ADDR_TINT, ti);
	endtask
	// Pins are levels; held long enough for the far sampler
	task pin(input int b);
		wb(1'h1, fspc_pkg::HOST_PINS, 32'h1 << b);
		rd(fspc_pkg::HOST_PINS, 32'h1 << b);
		repeat (8) @(posedge clk_sys);
		wb(1'h1, fspc_pkg::HOST_PINS, 32'h0);
		repeat (8) @(posedge clk_sys);
	endtask
	task wait_idle;
		for (int n = 0; n < 2000 && scan_running !== 1'h0; n++)
			@(posedge clk_sys);
		repeat (20) @(posedge clk_sys);
	endtask
	// Wire watch: bit taken at each serial clock fall inside a frame
	always @(negedge clk_sys)
	begin
		sclk_q <= link.sclk;
		stat_q <= link.scan_status_out;
		if (sclk_q && !link.sclk && !link.frame_sync_n)
			chk({31'h0, link.serial_data_in}, {31'h0, exp_bits.pop_front()});
		if (!stat_q && link.scan_status_out)
			stat_cnt++;
		if (link.sign_bit_out)
			sign_cnt++;
	end
	initial
	begin
		#300000;
		mismatches++;
		end_sim;
	end
	initial
	begin
		repeat (20) @(posedge clk_sys);
		rst <= 1'h0;
		for (k = 0; k < 5; k++)
			rd(8'h04 * k[7:0] + 8'h04, 32'h0);
		// Word-sent interrupt: raised, cleared by read, then masked
		wb(1'h1, fspc_pkg::HOST_IRQ_MASK, 32'h1);
		r = xs();
		send({fspc_pkg::ADDR_TINT, r[11:0]}, 1'h1);
		send({fspc_pkg::ADDR_TINT, r[23:12]}, 1'h0);
		chk(irq, 1'h1);
		rd(fspc_pkg::HOST_CMD, {15'h0, 1'h0, fspc_pkg::ADDR_TINT, r[23:12]});
		rd(fspc_pkg::HOST_IRQ_STAT, 32'h1);
		repeat (3) @(posedge clk_sys);
		chk(irq, 1'h0);
		wb(1'h1, fspc_pkg::HOST_IRQ_MASK, 32'h0);
		r = xs();
		word(fspc_pkg::ADDR_TINT, r[11:0]);
		chk(irq, 1'h0);
		// Auto scans: status at each increment, then only at the end
		for (k = 0; k < 2; k++)
		begin
			prog(k == 0 ? 12'h00f : 12'h00d, 12'h003, 12'h014);
			stat_cnt = 0;
			pin(fspc_pkg::PIN_TRIG);
			wait_idle;
			chk(stat_cnt, k == 0 ? 3 : 1);
			@(posedge clk_sys);
			d0 = dac_code;
			@(posedge clk_sys);
			chk(10'(dac_code - d0), 10'h007);
		end
		// Word-sent and status-rise events both left sticky
		rd(fspc_pkg::HOST_IRQ_STAT, 32'h3);
		chk(sign_cnt != 0, 1'h1);
		// External steps: the fourth trigger ends a two-increment scan
		prog(12'h004, 12'h002, 12'h005);
		stat_cnt = 0;
		sign_cnt = 0;
		for (k = 0; k < 4; k++)
		begin
			pin(fspc_pkg::PIN_TRIG);
			chk(scan_running, k < 3);
			chk(stat_cnt, k == 3);
		end
		chk(sign_cnt, 0);
		// Enables off: the scan runs but the status pin stays quiet
		prog(12'h001, 12'h003, 12'h014);
		stat_cnt = 0;
		pin(fspc_pkg::PIN_TRIG);
		wait_idle;
		chk(stat_cnt, 0);
		// Abort, then a control write, each stop a long scan
		prog(12'h005, 12'h003, 12'hfff);
		for (k = 0; k < 2; k++)
		begin
			pin(fspc_pkg::PIN_TRIG);
			chk(scan_running, 1'h1);
			if (k == 0)
				pin(fspc_pkg::PIN_ABORT);
			else
				word(fspc_pkg::ADDR_CTRL, 12'h005);
			chk(dac_code, fspc_pkg::DAC_MIDSCALE);
			chk(scan_running, 1'h0);
		end
		// Sleep in mid-scan parks the code at midscale
		pin(fspc_pkg::PIN_TRIG);
		wb(1'h1, fspc_pkg::HOST_PINS, 32'h1 << fspc_pkg::PIN_SLEEP);
		repeat (10) @(posedge clk_sys);
		chk(dac_code, fspc_pkg::DAC_MIDSCALE);
		chk(scan_running, 1'h1);
		wb(1'h1, fspc_pkg::HOST_PINS, 32'h0);
		// Park the scan before standby; a trigger in standby is ignored
		pin(fspc_pkg::PIN_ABORT);
		wb(1'h1, fspc_pkg::HOST_PINS, 32'h1 << fspc_pkg::PIN_SLEEP);
		repeat (8) @(posedge clk_sys);
		wb(1'h1, fspc_pkg::HOST_PINS, (32'h1 << fspc_pkg::PIN_SLEEP) |
			(32'h1 << fspc_pkg::PIN_TRIG));
		repeat (10) @(posedge clk_sys);
		chk(scan_running, 1'h0);
		chk(dac_code, fspc_pkg::DAC_MIDSCALE);
		wb(1'h1, fspc_pkg::HOST_PINS, 32'h0);
		chk(exp_bits.size(), 0);
		end_sim;
	end
endmodule // frequency_scan_pin_control_tb
`default_nettype wire

/* File: dv/fspc_link_props.sv */
// Concurrent checks on the link between host end and device end
`timescale 1ns/100ps
`default_nettype none
module fspc_link_props (
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic sclk,
	input wire logic frame_sync_n,
	input wire logic serial_data_in,
	input wire logic scan_trigger_in,
	input wire logic scan_abort_in,
	input wire logic sleep_in,
	input wire logic scan_status_out,
	input wire logic sign_bit_out,
	input wire logic [fspc_pkg::DAC_BITS-1:0] DAC_CODE,
	input wire logic SCAN_RUNNING
);
	logic sclk_q;
	logic [7:0] fall_cnt;
	logic dac_msb;
	assign dac_msb = DAC_CODE[fspc_pkg::DAC_BITS-1];
	// Falls per frame; cleared while frame high so each frame is judged alone
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
			fall_cnt <= 8'h00;
		else if (frame_sync_n)
			fall_cnt <= 8'h00;
		else if (sclk_q && !sclk)
			fall_cnt <= fall_cnt + 8'h01;
	end
	// Last serial clock level, idle high out of reset
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
			sclk_q <= 1'h1;
		else
			sclk_q <= sclk;
	end
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (RST);
	frame_edge_a: assert property ($fell(frame_sync_n) |-> sclk)
		else $error("frame fell with serial clock low");
	fall_frame_a: assert property ($fell(sclk) |-> !frame_sync_n)
		else $error("serial clock fell outside a frame");
	word_bound_a: assert property ($rose(frame_sync_n) |->
		fall_cnt != 8'h00 && fall_cnt[3:0] == 4'h0)
		else $error("frame raised off a word boundary");
	sclk_low_a: assert property ($fell(sclk) |=> !sclk [*7] ##1 sclk)
		else $error("serial clock low time wrong");
	data_hold_a: assert property ($fell(sclk) |->
		$stable(serial_data_in) ##1 $stable(serial_data_in))
		else $error("data moved around serial clock fall");
	sign_inv_a: assert property (sign_bit_out |->
		!dac_msb)
		else $error("sign pin high with code msb set");
	sleep_quiet_a: assert property (sleep_in [*8] |->
		DAC_CODE == fspc_pkg::DAC_MIDSCALE && !scan_status_out && !sign_bit_out)
		else $error("outputs active while asleep");
	abort_mid_a: assert property ($rose(scan_abort_in) |-> ##[1:8]
		(DAC_CODE == fspc_pkg::DAC_MIDSCALE && !SCAN_RUNNING))
		else $error("abort did not park the code");
	run_cause_a: assert property ($rose(SCAN_RUNNING) |->
		$past(scan_trigger_in, 3) && !sleep_in)
		else $error("scan started without trigger");
	status_width_a: assert property ($rose(scan_status_out) |=>
		scan_status_out [*3])
		else $error("status pulse too short");
endmodule // fspc_link_props
`default_nettype wire

/* File: rtl/fspc_device.sv */
// Scan generator device end: serial loader, scan sequencer, outputs
//
// How it works
// - Sixteen bit word, address first, MSB first
// - Sample data on each serial clock fall
// - Bits accepted only while frame sync low
// - Abort rise resets scan, DAC to midscale
// - Trigger rise initialises and starts the scan; here only from idle, ignored once done until an abort or control write
// - Auto mode: one trigger runs whole scan
// - External mode: one increment per trigger rise
// - Status pin shows end or each increment
// - Status pin inactive unless its enable set
// - Sign pin is inverted DAC code MSB
// - Sign pin off unless its enable set
// - Sleep high freezes master clock work
// - Host resets device before asserting sleep
// - Output frequency is word fraction times clock
// - Back-to-back words under held frame sync
// - Control write acts like an abort
// - Last frequency held after scan ends
//
// Design decisions made here: register access over Wishbone and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module fspc_device (
	fspc_link_if.dev LINK,
	input wire logic CLK_SYS,
	input wire logic RST,
	output logic [fspc_pkg::DAC_BITS-1:0] DAC_CODE,
	output logic SCAN_RUNNING
);
	localparam int I_SCLK = 0;
	localparam int I_FS = 1;
	localparam int I_SD = 2;
	localparam int I_TRIG = 3;
	localparam int I_ABORT = 4;
	localparam int I_SLEEP = 5;
	// Serial clock and frame sync idle high
	localparam logic [5:0] PIN_RST = 6'h03;

	logic [5:0] pin_raw;
	logic [5:0] sync1;
	logic [5:0] sync2;
	logic [5:0] sync3;
	logic [5:0] pin_lvl;
	logic [5:0] next_pin_lvl;
	logic sclk_fall;
	logic trig_rise;
	logic abort_rise;
	logic run_en;
	logic [3:0] bit_cnt;
	logic [fspc_pkg::WORD_BITS-2:0] shift;
	logic word_stb;
	logic [fspc_pkg::WORD_BITS-1:0] word;
	logic [fspc_pkg::ADDR_BITS-1:0] word_addr;
	logic [fspc_pkg::DATA_BITS-1:0] word_data;
	logic ctrl_wr;
	logic [11:0] ctrl;
	logic [fspc_pkg::FREQ_BITS-1:0] start_freq;
	logic [fspc_pkg::FREQ_BITS-1:0] delta_freq;
	logic [11:0] nincr;
	logic [11:0] tint;
	fspc_pkg::fspc_scan_state_type state;
	logic [fspc_pkg::FREQ_BITS-1:0] freq;
	logic [11:0] incr;
	logic [11:0] tcnt;
	logic step;
	logic last_step;
	logic inc_ev;
	logic eos_ev;
	logic [fspc_pkg::FREQ_BITS-1:0] phase;
	logic [fspc_pkg::DAC_BITS-1:0] next_dac;
	logic [2:0] hold_cnt;

	assign pin_raw = {LINK.sleep_in, LINK.scan_abort_in,
		LINK.scan_trigger_in, LINK.serial_data_in,
		LINK.frame_sync_n, LINK.sclk};

	// Three-flop samplers; a level counts once stages two and three agree
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			sync1 <= PIN_RST;
			sync2 <= PIN_RST;
			sync3 <= PIN_RST;
			pin_lvl <= PIN_RST;
		end
		else
		begin
			sync1 <= pin_raw;
			sync2 <= sync1;
			sync3 <= sync2;
			pin_lvl <= next_pin_lvl;
		end
	end

	// Filtered levels and their edges, never looking at stage one
	assign next_pin_lvl = ((sync2 ~^ sync3) & sync3) |
		((sync2 ^ sync3) & pin_lvl);
	assign sclk_fall = pin_lvl[I_SCLK] & ~next_pin_lvl[I_SCLK];
	assign trig_rise = ~pin_lvl[I_TRIG] & next_pin_lvl[I_TRIG];
	assign abort_rise = ~pin_lvl[I_ABORT] & next_pin_lvl[I_ABORT];
	assign run_en = ~pin_lvl[I_SLEEP];

	// Shift register; the counter wraps so held frames chain words
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			bit_cnt <= 4'h0;
			shift <= 15'h0000;
		end
		else if (pin_lvl[I_FS])
			bit_cnt <= 4'h0;
		else if (sclk_fall)
		begin
			shift <= {shift[13:0], next_pin_lvl[I_SD]};
			bit_cnt <= bit_cnt + 4'h1;
		end
	end

	// Word complete on the sixteenth fall, first bit landing on top
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			word_stb <= 1'b0;
			word <= 16'h0000;
		end
		else
		begin
			word_stb <= ~pin_lvl[I_FS] & sclk_fall & (bit_cnt == 4'hf);
			if (~pin_lvl[I_FS] & sclk_fall & (bit_cnt == 4'hf))
				word <= {shift, next_pin_lvl[I_SD]};
		end
	end

	assign word_addr = word[15:12];
	assign word_data = word[11:0];

	// Scan parameter and control registers
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			ctrl <= fspc_pkg::CTRL_RST;
			ctrl_wr <= 1'b0;
			start_freq <= 24'h000000;
			delta_freq <= 24'h000000;
			nincr <= 12'h000;
			tint <= 12'h000;
		end
		else
		begin
			ctrl_wr <= word_stb & (word_addr == fspc_pkg::ADDR_CTRL);
			if (word_stb)
			begin
				case (word_addr)
					fspc_pkg::ADDR_CTRL: ctrl <= word_data;
					fspc_pkg::ADDR_START_LO: start_freq[11:0] <= word_data;
					fspc_pkg::ADDR_START_HI: start_freq[23:12] <= word_data;
					fspc_pkg::ADDR_DELTA_LO: delta_freq[11:0] <= word_data;
					fspc_pkg::ADDR_DELTA_HI: delta_freq[23:12] <= word_data;
					fspc_pkg::ADDR_NINCR: nincr <= word_data;
					fspc_pkg::ADDR_TINT: tint <= word_data;
					default: ctrl <= ctrl;
				endcase
			end
		end
	end

	// Step source: interval timer in auto mode, trigger edges otherwise
	assign step = ctrl[fspc_pkg::CTRL_AUTO] ?
		(tcnt == tint) : trig_rise;
	assign last_step = (incr == nincr);
	assign inc_ev = run_en & (state == fspc_pkg::FSPC_RUN) & step & ~last_step;
	assign eos_ev = run_en & (state == fspc_pkg::FSPC_RUN) & step & last_step;

	// Scan sequencer; abort and control writes win over everything
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			state <= fspc_pkg::FSPC_IDLE;
			freq <= 24'h000000;
			incr <= 12'h000;
			tcnt <= 12'h000;
		end
		else if (abort_rise | ctrl_wr)
		begin
			state <= fspc_pkg::FSPC_IDLE;
			incr <= 12'h000;
			tcnt <= 12'h000;
		end
		else if (run_en)
		begin
			case (state)
				fspc_pkg::FSPC_IDLE:
					if (trig_rise)
					begin
						freq <= start_freq;
						incr <= 12'h000;
						tcnt <= 12'h000;
						state <= fspc_pkg::FSPC_RUN;
					end
				fspc_pkg::FSPC_RUN:
					if (step)
					begin
						tcnt <= 12'h000;
						if (last_step)
							state <= fspc_pkg::FSPC_DONE;
						else
						begin
							freq <= freq + delta_freq;
							incr <= incr + 12'h001;
						end
					end
					else
						tcnt <= tcnt + 12'h001;
				fspc_pkg::FSPC_DONE:
					state <= fspc_pkg::FSPC_DONE;
				default:
					state <= fspc_pkg::FSPC_IDLE;
			endcase
		end
	end

	// Phase accumulator starts from zero phase at each scan start
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
			phase <= 24'h000000;
		else if (abort_rise | ctrl_wr | (state == fspc_pkg::FSPC_IDLE))
			phase <= 24'h000000;
		else if (run_en)
			phase <= phase + freq;
	end

	// DAC rests at midscale when idle or asleep
	assign next_dac = ((state == fspc_pkg::FSPC_IDLE) | ~run_en |
		abort_rise | ctrl_wr) ? fspc_pkg::DAC_MIDSCALE :
		phase[23:14];

	// DAC code, sign pin and running flag
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			DAC_CODE <= fspc_pkg::DAC_MIDSCALE;
			LINK.sign_bit_out <= 1'b0;
			SCAN_RUNNING <= 1'b0;
		end
		else
		begin
			DAC_CODE <= next_dac;
			LINK.sign_bit_out <= ctrl[fspc_pkg::CTRL_SIGN_EN] & run_en &
				~next_dac[9];
			SCAN_RUNNING <= (state == fspc_pkg::FSPC_RUN);
		end
	end

	// Status pulse stretched so the host's samplers cannot miss it
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
			hold_cnt <= 3'h0;
		else if (ctrl[fspc_pkg::CTRL_SRC_SEL] ? inc_ev : eos_ev)
			hold_cnt <= fspc_pkg::STATUS_HOLD;
		else if (hold_cnt != 3'h0)
			hold_cnt <= hold_cnt - 3'h1;
	end

	// Status pin gated by its enable
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
			LINK.scan_status_out <= 1'b0;
		else
			LINK.scan_status_out <= ctrl[fspc_pkg::CTRL_STAT_EN] & run_en &
				(hold_cnt != 3'h0);
	end
endmodule // fspc_device
`default_nettype wire

/* File: rtl/fspc_host.sv */
// Host end: Wishbone registers driving the serial port and control pins
`timescale 1ns/100ps
`default_nettype none
module fspc_host (
	fspc_link_if.host LINK,
	input wire logic CLK_SYS,
	input wire logic RST,
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	output logic IRQ
);
	logic req;
	logic wr;
	logic rd;
	logic [16:0] cmd;
	logic [2:0] pins;
	logic [1:0] irq_stat;
	logic [1:0] irq_mask;
	logic [1:0] sync1;
	logic [1:0] sync2;
	logic [1:0] sync3;
	logic [1:0] lvl;
	logic [1:0] next_lvl;
	logic scan_rise;
	logic word_done;
	logic start;
	fspc_pkg::fspc_tx_state_type tx_state;
	logic [3:0] bit_idx;
	logic [7:0] div_cnt;
	logic half_tick;
	logic [31:0] next_rdata;

	// One-cycle answer; ack drops the cycle after it is given
	assign req = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
	assign wr = req & WB_WE_I & WB_SEL_I[0];
	assign rd = req & ~WB_WE_I;
	// A word written while a word is still shifting is dropped
	assign start = wr & (WB_ADR_I == fspc_pkg::HOST_CMD) &
		(tx_state == fspc_pkg::FSPC_TX_IDLE) & (&WB_SEL_I[2:1]);

	// Read data mux, unmapped offsets read zero
	always_comb
	begin
		next_rdata = 32'h00000000;
		case (WB_ADR_I)
			fspc_pkg::HOST_CMD: next_rdata = {15'h0000, cmd};
			fspc_pkg::HOST_STATUS: next_rdata = {29'h00000000, lvl,
				(tx_state != fspc_pkg::FSPC_TX_IDLE)};
			fspc_pkg::HOST_PINS: next_rdata = {29'h00000000, pins};
			fspc_pkg::HOST_IRQ_STAT: next_rdata = {30'h00000000, irq_stat};
			fspc_pkg::HOST_IRQ_MASK: next_rdata = {30'h00000000, irq_mask};
			default: next_rdata = 32'h00000000;
		endcase
	end

	// Bus answer and software registers
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h00000000;
			cmd <= 17'h00000;
			pins <= 3'h0;
			irq_mask <= 2'h0;
		end
		else
		begin
			WB_ACK_O <= req;
			if (rd)
				WB_DAT_O <= next_rdata;
			if (start)
				cmd <= WB_DAT_I[16:0];
			if (wr & (WB_ADR_I == fspc_pkg::HOST_PINS))
				pins <= WB_DAT_I[2:0];
			if (wr & (WB_ADR_I == fspc_pkg::HOST_IRQ_MASK))
				irq_mask <= WB_DAT_I[1:0];
		end
	end

	// Sticky events, cleared by a read; a new event beats the clear
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			irq_stat <= 2'h0;
			IRQ <= 1'b0;
		end
		else
		begin
			irq_stat <= ((rd & (WB_ADR_I == fspc_pkg::HOST_IRQ_STAT)) ?
				2'h0 : irq_stat) | {scan_rise, word_done};
			IRQ <= |(irq_stat & irq_mask);
		end
	end

	// Device pins pass three flops before use
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			sync1 <= 2'h0;
			sync2 <= 2'h0;
			sync3 <= 2'h0;
			lvl <= 2'h0;
		end
		else
		begin
			sync1 <= {LINK.sign_bit_out, LINK.scan_status_out};
			sync2 <= sync1;
			sync3 <= sync2;
			lvl <= next_lvl;
		end
	end

	assign next_lvl = ((sync2 ~^ sync3) & sync3) | ((sync2 ^ sync3) & lvl);
	assign scan_rise = ~lvl[0] & next_lvl[0];

	// Control pins are plain register levels under software timing
	assign LINK.scan_trigger_in = pins[fspc_pkg::PIN_TRIG];
	assign LINK.scan_abort_in = pins[fspc_pkg::PIN_ABORT];
	assign LINK.sleep_in = pins[fspc_pkg::PIN_SLEEP];

	// Half-period divider, only counting while a word is shifting
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
			div_cnt <= 8'h00;
		else if ((tx_state == fspc_pkg::FSPC_TX_IDLE) | half_tick)
			div_cnt <= 8'(fspc_pkg::SCLK_HALF - 1);
		else
			div_cnt <= div_cnt - 8'h01;
	end

	assign half_tick = (tx_state != fspc_pkg::FSPC_TX_IDLE) &
		(div_cnt == 8'h00);
	assign word_done = half_tick & (tx_state == fspc_pkg::FSPC_TX_LOW) &
		(bit_idx == 4'h0);

	// Transmitter: data moves on rising serial clock, device reads on fall
	always_ff @(posedge CLK_SYS or posedge RST)
	begin
		if (RST)
		begin
			tx_state <= fspc_pkg::FSPC_TX_IDLE;
			bit_idx <= 4'h0;
			LINK.sclk <= 1'b1;
			LINK.frame_sync_n <= 1'b1;
			LINK.serial_data_in <= 1'b0;
		end
		else
		begin
			case (tx_state)
				fspc_pkg::FSPC_TX_IDLE:
					if (start)
					begin
						LINK.frame_sync_n <= 1'b0;
						LINK.serial_data_in <= WB_DAT_I[15];
						bit_idx <= 4'hf;
						tx_state <= fspc_pkg::FSPC_TX_HIGH;
					end
				fspc_pkg::FSPC_TX_HIGH:
					if (half_tick)
					begin
						LINK.sclk <= 1'b0;
						tx_state <= fspc_pkg::FSPC_TX_LOW;
					end
				fspc_pkg::FSPC_TX_LOW:
					if (half_tick)
					begin
						LINK.sclk <= 1'b1;
						if (bit_idx == 4'h0)
						begin
							LINK.frame_sync_n <= ~cmd[fspc_pkg::CMD_KEEP];
							tx_state <= fspc_pkg::FSPC_TX_IDLE;
						end
						else
						begin
							LINK.serial_data_in <= cmd[bit_idx - 4'h1];
							bit_idx <= bit_idx - 4'h1;
							tx_state <= fspc_pkg::FSPC_TX_HIGH;
						end
					end
				default:
					tx_state <= fspc_pkg::FSPC_TX_IDLE;
			endcase
		end
	end
endmodule // fspc_host
`default_nettype wire
